/* rtl/light_level_pkg.sv */
// shared constants, register map and state types of the light level readout
package light_level_pkg;

   // ==========================================================
   // register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int IDX_W = 6;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 7;
   localparam logic [1:0] WORD_ALIGNED = 2'h0;
   localparam int BE_LOW_LANE = 0;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [IDX_W-1:0] IDX_DARK_THRESHOLD = 6'h1F;
   localparam logic [IDX_W-1:0] IDX_DARK_HYSTERESIS = 6'h20;
   localparam logic [IDX_W-1:0] IDX_SENSOR1_RESULT_LOW = 6'h21;
   localparam logic [IDX_W-1:0] IDX_SENSOR1_RESULT_HIGH = 6'h22;
   localparam logic [IDX_W-1:0] IDX_SENSOR2_RESULT_LOW = 6'h23;
   localparam logic [IDX_W-1:0] IDX_SENSOR2_RESULT_HIGH = 6'h24;
   localparam logic [IDX_W-1:0] IDX_SENSE_CONTROL = 6'h28;
   localparam logic [IDX_W-1:0] IDX_SENSE_STATUS = 6'h29;

   // ==========================================================
   // field layouts and reset values
   localparam int CODE_W = 8;
   localparam int VALUE_W = 13;
   localparam int LOW_LSB = 0;
   localparam int LOW_MSB = 7;
   localparam int HIGH_LSB = 8;
   localparam int HIGH_MSB = 12;
   localparam int RSVD_W = 3;
   localparam int NUM_SENSORS = 2;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STAT_DARK_BIT = 0;
   localparam int STAT_ENABLE_BIT = 1;
   localparam int STAT_COUNT_LSB = 8;
   localparam int STAT_COUNT_MSB = 15;
   localparam int COUNT_W = 8;
   localparam logic [CODE_W-1:0] HYS_RESET = 8'h00;
   localparam logic [CODE_W-1:0] THR_RESET = 8'h00;
   localparam logic [VALUE_W-1:0] VALUE_RESET = 13'h0000;

   // ==========================================================
   // hysteresis current scale, in nA per code step
   localparam int HYS_NA_W = 18;
   localparam logic [HYS_NA_W-1:0] HYS_STEP_NA = 18'h0021C;
   localparam logic [HYS_NA_W-1:0] HYS_FULL_NA = 18'h219E4;

   // ==========================================================
   // refresh timing
   localparam int REFRESH_MS = 32'h0000_0050;
   localparam int CLK_MHZ = 32'h0000_00FA;
   localparam int KHZ_PER_MHZ = 32'h0000_03E8;
   localparam int REFRESH_CYCLES_DEF = REFRESH_MS * CLK_MHZ * KHZ_PER_MHZ;
   localparam int TIMER_W = 25;

   // ==========================================================
   // carriers and state types
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0] byteenable;
   } avs_req_type;

   typedef struct packed {
      logic [CODE_W-1:0] high;
      logic [CODE_W-1:0] low;
   } result_bytes_type;

   typedef struct packed {
      logic [VALUE_W-1:0] value;
   } result_state_type;

   typedef struct packed {
      logic [CODE_W-1:0] hys;
      logic [CODE_W-1:0] thr;
      logic sense_en;
      logic dark;
      logic [TIMER_W-1:0] timer;
      logic load;
      logic [COUNT_W-1:0] refresh_count;
      logic waitreq;
      logic [DATA_W-1:0] rdata;
      logic [HYS_NA_W-1:0] hys_na;
   } light_state_type;

endpackage : light_level_pkg

/* rtl/light_result_reg.sv */
// one sensor's conversion result, held and split into low and high bytes
`timescale 1ns/1ps

module light_result_reg (
   // clock, reset and enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // refresh strobe and converter value
   input wire logic i_load,
   input wire logic [light_level_pkg::VALUE_W-1:0] i_value,
   // byte view of the held value
   output light_level_pkg::result_bytes_type o_bytes
);

   light_level_pkg::result_state_type state_ff;
   light_level_pkg::result_state_type nxt_state;

   // =======================================================
   // next state: capture only on the refresh strobe
   always_comb begin
      nxt_state = state_ff;
      if (i_ce && i_load) begin
         nxt_state.value = i_value;
      end
   end

   // register the state
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_ff.value <= light_level_pkg::VALUE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // byte split, reserved high bits forced to zero
   assign o_bytes.low = state_ff.value[light_level_pkg::LOW_MSB:
                                       light_level_pkg::LOW_LSB];
   assign o_bytes.high = {{light_level_pkg::RSVD_W{1'b0}},
                          state_ff.value[light_level_pkg::HIGH_MSB:
                                         light_level_pkg::HIGH_LSB]};

endmodule : light_result_reg

/* rtl/light_sensor_level_readout.sv */
// dark-level comparator, refresh timer and register slave of the readout
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps

module light_sensor_level_readout #(
   parameter int unsigned REFRESH_CYCLES =
      light_level_pkg::REFRESH_CYCLES_DEF
) (
   // clock, reset and enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // avalon-mm slave
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [light_level_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic [light_level_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [light_level_pkg::BE_W-1:0] i_avs_byteenable,
   output logic o_avs_waitrequest,
   output logic [light_level_pkg::DATA_W-1:0] o_avs_readdata,
   // converter and comparator inputs, same clock
   input wire logic [light_level_pkg::CODE_W-1:0] i_dark_cmp_level,
   input wire logic [light_level_pkg::VALUE_W-1:0] i_sensor1_value,
   input wire logic [light_level_pkg::VALUE_W-1:0] i_sensor2_value,
   // backlight mode and hysteresis current
   output logic o_dark_mode,
   output logic [light_level_pkg::HYS_NA_W-1:0] o_hys_current_na
);

   // =======================================================
   // byte map, index times four
   // 0x7C threshold, 0x80 hysteresis
   // 0x84 and 0x88 sensor one low, high
   // 0x8C and 0x90 sensor two low, high
   // 0xA0 control, bit 0 sense enable
   // 0xA4 status: dark, enable, count
   // misaligned or unmapped: reads zero
   // results and status drop writes
   // only byte lane 0 carries a write
   // no error response on the bus

   // bus walk, one access:
   //   edge 0 accepts, waitrequest high
   //   cycle 1 waitrequest low, data valid
   //   edge 1 completes, a write lands here
   //   cycle 2 idle, next request may stand
   // so each access takes two cycles

   // refresh walk, sensing enabled:
   //   timer counts every enabled cycle
   //   last count raises load for a cycle
   //   next edge copies both sensors
   //   the status count stepped as load rose
   // default period is eighty ms

   // comparator walk, each enabled cycle:
   //   below threshold: dark next edge
   //   above the office level: office
   //   in between: mode is kept

   // hysteresis current:
   //   code times the step, in nA
   //   full code gives the top value
   //   lags a new code by one cycle

   // read data:
   //   latched when a read is taken
   //   held until the next read

   // refresh count:
   //   steps once per load
   //   wraps silently at the top

   // sensing off:
   //   timer cleared, results kept
   //   status enable bit reads zero

   // clock enable low:
   //   every flop holds, holders too
   //   a pending load waits for it
   //   reset still acts

   // after reset:
   //   codes zero, sensing off
   //   results and read data zero
   //   waitrequest high, office mode

   // =======================================================
   // local types and signals
   // timer wraps at REFRESH_CYCLES-1:
   // keep it at two or more, in range
   // compare one bit wider so the sum
   // of the codes never wraps
   // holders hand over byte pairs
   localparam logic [light_level_pkg::TIMER_W-1:0] TIMER_LAST =
      light_level_pkg::TIMER_W'(REFRESH_CYCLES - 1);
   localparam int CMP_W = light_level_pkg::CODE_W + 1;

   light_level_pkg::light_state_type state_ff;
   light_level_pkg::light_state_type nxt_state;
   light_level_pkg::avs_req_type avs_req;
   light_level_pkg::result_bytes_type res_bytes
      [0:light_level_pkg::NUM_SENSORS-1];
   logic [light_level_pkg::VALUE_W-1:0] sensor_value
      [0:light_level_pkg::NUM_SENSORS-1];
   logic [CMP_W-1:0] office_level;
   logic low_lane_write;

   // =======================================================
   // decode helpers
   // reads and writes share hits(), so
   // alignment is judged one way

   // word index of a byte address
   function automatic logic [light_level_pkg::IDX_W-1:0] word_index(
      input logic [light_level_pkg::ADDR_W-1:0] addr
   );
      word_index = addr[light_level_pkg::IDX_MSB:light_level_pkg::IDX_LSB];
   endfunction : word_index

   // true when the address is aligned and hits the given register
   function automatic logic hits(
      input logic [light_level_pkg::ADDR_W-1:0] addr,
      input logic [light_level_pkg::IDX_W-1:0] idx
   );
      hits = (addr[light_level_pkg::IDX_LSB-1:0] ==
              light_level_pkg::WORD_ALIGNED) && (word_index(addr) == idx);
   endfunction : hits

   // hysteresis code scaled to photosensor current in nA
   function automatic logic [light_level_pkg::HYS_NA_W-1:0] hys_to_na(
      input logic [light_level_pkg::CODE_W-1:0] code
   );
      logic [light_level_pkg::HYS_NA_W-1:0] wide;
      // widen first so no bit is lost
      wide = light_level_pkg::HYS_NA_W'(code);
      hys_to_na = light_level_pkg::HYS_NA_W'(
                     wide * light_level_pkg::HYS_STEP_NA);
   endfunction : hys_to_na

   // =======================================================
   // bus carrier and sensor array
   // one bundle feeds decode and handshake
   // sensors share this clock: no sync,
   // read only on a refresh
   assign avs_req.read = i_avs_read;
   assign avs_req.write = i_avs_write;
   assign avs_req.address = i_avs_address;
   assign avs_req.writedata = i_avs_writedata;
   assign avs_req.byteenable = i_avs_byteenable;
   assign low_lane_write =
      avs_req.byteenable[light_level_pkg::BE_LOW_LANE];
   // index 0 is sensor one
   assign sensor_value[0] = i_sensor1_value;
   assign sensor_value[1] = i_sensor2_value;

   // office level is the threshold plus hysteresis, one bit wider
   // zero hysteresis still needs the
   // input to pass the threshold
   assign office_level = CMP_W'(state_ff.thr) + CMP_W'(state_ff.hys);

   // =======================================================
   // result holders, one per sensor
   // one load flag for both holders,
   // so both sensors share an edge
   // low then high may straddle a
   // refresh: read the pair twice
   // each holder sees its own sensor
   generate
      for (genvar s = 0; s < light_level_pkg::NUM_SENSORS; s++) begin :
         g_result
         light_result_reg u_result (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_ce(i_ce),
            .i_load(state_ff.load),
            .i_value(sensor_value[s]),
            .o_bytes(res_bytes[s])
         );
      end
   endgenerate

   // =======================================================
   // read multiplexer, unmapped and misaligned words read zero
   // word built from state at acceptance
   // upper lanes zero but the count
   // the count wraps after 256 loads
   // reserved high bits come back zero
   function automatic logic [light_level_pkg::DATA_W-1:0] read_word(
      input logic [light_level_pkg::ADDR_W-1:0] addr,
      input light_level_pkg::light_state_type st,
      input light_level_pkg::result_bytes_type r1,
      input light_level_pkg::result_bytes_type r2
   );
      logic [light_level_pkg::DATA_W-1:0] w;
      // start clear
      w = '0;
      if (hits(addr, light_level_pkg::IDX_DARK_THRESHOLD)) begin
         w[light_level_pkg::CODE_W-1:0] = st.thr;
      end else if (hits(addr, light_level_pkg::IDX_DARK_HYSTERESIS)) begin
         w[light_level_pkg::CODE_W-1:0] = st.hys;
      end else if (hits(addr, light_level_pkg::IDX_SENSOR1_RESULT_LOW))
      begin
         w[light_level_pkg::CODE_W-1:0] = r1.low;
      end else if (hits(addr, light_level_pkg::IDX_SENSOR1_RESULT_HIGH))
      begin
         w[light_level_pkg::CODE_W-1:0] = r1.high;
      end else if (hits(addr, light_level_pkg::IDX_SENSOR2_RESULT_LOW))
      begin
         w[light_level_pkg::CODE_W-1:0] = r2.low;
      end else if (hits(addr, light_level_pkg::IDX_SENSOR2_RESULT_HIGH))
      begin
         w[light_level_pkg::CODE_W-1:0] = r2.high;
      end else if (hits(addr, light_level_pkg::IDX_SENSE_CONTROL)) begin
         w[light_level_pkg::CTRL_ENABLE_BIT] = st.sense_en;
      end else if (hits(addr, light_level_pkg::IDX_SENSE_STATUS)) begin
         w[light_level_pkg::STAT_DARK_BIT] = st.dark;
         w[light_level_pkg::STAT_ENABLE_BIT] = st.sense_en;
         w[light_level_pkg::STAT_COUNT_MSB:light_level_pkg::STAT_COUNT_LSB]
            = st.refresh_count;
      end
      read_word = w;
   endfunction : read_word

   // =======================================================
   // next state of the whole block
   // enable low leaves the copy as is:
   // timer, mode, current, handshake hold
   // a waiting master just waits longer
   always_comb begin
      nxt_state = state_ff;
      if (i_ce) begin
         // refresh timer runs only while sensing is enabled
         // load lasts one enabled cycle; off
         // clears the timer for a fresh period
         nxt_state.load = 1'b0;
         if (!state_ff.sense_en) begin
            nxt_state.timer = '0;
         end else if (state_ff.timer == TIMER_LAST) begin
            nxt_state.timer = '0;
            nxt_state.load = 1'b1;
            nxt_state.refresh_count = state_ff.refresh_count +
                                      light_level_pkg::COUNT_W'(1);
         end else begin
            nxt_state.timer = state_ff.timer +
                              light_level_pkg::TIMER_W'(1);
         end

         // dark comparator with hysteresis, state kept in between
         // strict compares: equal keeps mode,
         // below threshold is checked first
         if (CMP_W'(i_dark_cmp_level) < CMP_W'(state_ff.thr)) begin
            nxt_state.dark = 1'b1;
         end else if (CMP_W'(i_dark_cmp_level) > office_level) begin
            nxt_state.dark = 1'b0;
         end

         // hysteresis current follows the code one cycle later
         // output comes from a flop
         nxt_state.hys_na = hys_to_na(state_ff.hys);

         // bus handshake: wait one cycle, then answer for one cycle
         // waitrequest idles high; a request
         // seen then is accepted and the flag
         // drops for exactly one cycle
         // read data stands until next read,
         // so a late sampler sees the same word
         if (state_ff.waitreq) begin
            if (avs_req.read || avs_req.write) begin
               nxt_state.waitreq = 1'b0;
               if (avs_req.read) begin
                  nxt_state.rdata = read_word(avs_req.address, state_ff,
                                              res_bytes[0], res_bytes[1]);
               end
            end
         end else begin
            nxt_state.waitreq = 1'b1;
            // writes land only at the answering edge, low lane only
            // lane 0 off: answered, no change
            if (avs_req.write && low_lane_write) begin
               if (hits(avs_req.address,
                        light_level_pkg::IDX_DARK_THRESHOLD)) begin
                  nxt_state.thr =
                     avs_req.writedata[light_level_pkg::CODE_W-1:0];
               end else if (hits(avs_req.address,
                                 light_level_pkg::IDX_DARK_HYSTERESIS))
               begin
                  nxt_state.hys =
                     avs_req.writedata[light_level_pkg::CODE_W-1:0];
               end else if (hits(avs_req.address,
                                 light_level_pkg::IDX_SENSE_CONTROL))
               begin
                  nxt_state.sense_en =
                     avs_req.writedata[light_level_pkg::CTRL_ENABLE_BIT];
               end
               // result, status and unmapped words ignore writes
            end
         end
      end
   end

   // =======================================================
   // register the whole block state
   // reset beats the enable: every
   // field loads its reset value
   // waitrequest leaves reset high, so
   // no early acceptance after release
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_ff.hys <= light_level_pkg::HYS_RESET;
         state_ff.thr <= light_level_pkg::THR_RESET;
         state_ff.sense_en <= 1'b0;
         state_ff.dark <= 1'b0;
         state_ff.timer <= '0;
         state_ff.load <= 1'b0;
         state_ff.refresh_count <= '0;
         state_ff.waitreq <= 1'b1;
         state_ff.rdata <= '0;
         state_ff.hys_na <= '0;
      end else begin
         // whole copy in one step
         state_ff <= nxt_state;
      end
   end

   // =======================================================
   // outputs straight from the state flops
   // no logic between flop and pin,
   // so output timing is fixed
   assign o_avs_waitrequest = state_ff.waitreq;
   assign o_avs_readdata = state_ff.rdata;
   assign o_dark_mode = state_ff.dark;
   assign o_hys_current_na = state_ff.hys_na;

endmodule : light_sensor_level_readout

/* tb/light_sensor_level_readout_props.sv */
// assertion checker for the light level readout ports
`timescale 1ns/1ps

module light_sensor_level_readout_props #(
   parameter int unsigned REFRESH_CYCLES = 16
) (
   // clock, reset and enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // register bus
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [light_level_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic [light_level_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [light_level_pkg::BE_W-1:0] i_avs_byteenable,
   input wire logic o_avs_waitrequest,
   input wire logic [light_level_pkg::DATA_W-1:0] o_avs_readdata,
   // sensing side
   input wire logic [light_level_pkg::CODE_W-1:0] i_dark_cmp_level,
   input wire logic [light_level_pkg::VALUE_W-1:0] i_sensor1_value,
   input wire logic [light_level_pkg::VALUE_W-1:0] i_sensor2_value,
   input wire logic o_dark_mode,
   input wire logic [light_level_pkg::HYS_NA_W-1:0] o_hys_current_na
);
   // ==========================================================
   // shadow of threshold and hysteresis, taken at completing write edges
   logic [7:0] thr_ff;
   logic [7:0] hys_ff;
   logic wr_done;
   logic [8:0] upper;
   assign wr_done = i_ce && i_avs_write && !o_avs_waitrequest &&
      i_avs_byteenable[0];
   assign upper = {1'b0, thr_ff} + {1'b0, hys_ff};
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         thr_ff <= 8'h00;
         hys_ff <= 8'h00;
      end else if (wr_done && i_avs_address == 8'h7C) begin
         thr_ff <= i_avs_writedata[7:0];
      end else if (wr_done && i_avs_address == 8'h80) begin
         hys_ff <= i_avs_writedata[7:0];
      end
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence req_s;
      i_ce && (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence ans_s;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   bus_answer_a: assert property (req_s |=> ans_s)
      else $error("bus answer not one cycle after acceptance");
   idle_wait_a: assert property (!o_avs_waitrequest |->
      $past(i_avs_read || i_avs_write))
      else $error("waitrequest low without a request");
   enter_dark_a: assert property (
      i_ce && i_dark_cmp_level < thr_ff |=> o_dark_mode)
      else $error("dark mode not entered below threshold");
   leave_dark_a: assert property (
      i_ce && {1'b0, i_dark_cmp_level} > upper |=> !o_dark_mode)
      else $error("dark mode not left above threshold plus hysteresis");
   dark_hold_a: assert property (
      i_ce && i_dark_cmp_level >= thr_ff &&
      {1'b0, i_dark_cmp_level} <= upper |=> $stable(o_dark_mode))
      else $error("mode changed inside the hysteresis band");
   hys_current_a: assert property (
      !$past(i_sys_rst) |->
      o_hys_current_na == 18'($past(hys_ff)) * 18'h0021C)
      else $error("hysteresis current not code times step");
   hys_readback_a: assert property (
      i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h80 |->
      o_avs_readdata == {24'h000000, hys_ff})
      else $error("hysteresis readback differs from written code");
   high_rsvd_a: assert property (
      i_avs_read && !o_avs_waitrequest &&
      (i_avs_address == 8'h88 || i_avs_address == 8'h90) |->
      o_avs_readdata[31:5] == 27'h0000000)
      else $error("reserved high result bits not zero");
endmodule : light_sensor_level_readout_props

/* tb/light_sensor_level_readout_bench.sv */
// self-checking bench of the light level readout
`timescale 1ns/1ps

module light_sensor_level_readout_bench;
   localparam int unsigned REFRESH = 16;
   logic i_clk = 1'b0;
   logic i_sys_rst, i_ce, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic o_dark_mode;
   logic [7:0] i_avs_address, i_dark_cmp_level;
   logic [31:0] i_avs_writedata, o_avs_readdata, d;
   logic [3:0] i_avs_byteenable;
   logic [12:0] i_sensor1_value, i_sensor2_value;
   logic [17:0] o_hys_current_na;
   int failures = 0;
   int check_count = 0;

   // ==========================================================
   // clock and design
   always #2 i_clk = ~i_clk;
   light_sensor_level_readout #(.REFRESH_CYCLES(REFRESH)) uut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_address(i_avs_address), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_waitrequest(o_avs_waitrequest),
      .o_avs_readdata(o_avs_readdata), .i_dark_cmp_level(i_dark_cmp_level),
      .i_sensor1_value(i_sensor1_value), .i_sensor2_value(i_sensor2_value),
      .o_dark_mode(o_dark_mode), .o_hys_current_na(o_hys_current_na));

   // ==========================================================
   // shared tasks
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   // one access, held until waitrequest is seen low, then released
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, input logic [3:0] be);
      int n;
      n = 0;
      i_avs_read <= !wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= wd;
      i_avs_byteenable <= be;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 20) begin
            failures++;
            end_of_test();
         end
         @(posedge i_clk);
      end
      d = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd, 4'hF);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000, 4'hF);
      check(d, exp);
   endtask : rd_chk

   // ==========================================================
   // scenarios
   task automatic t_reset_map();
      rd_chk(8'h80, 32'h00000000);
      for (logic [7:0] a = 8'h84; a <= 8'h90; a += 8'h04) begin
         rd_chk(a, 32'h00000000);
      end
      rd_chk(8'h81, 32'h00000000);
      rd_chk(8'hFC, 32'h00000000);
      $display("test reset_map done");
   endtask : t_reset_map
   task automatic t_hysteresis();
      wr(8'h80, 32'h000000FF);
      rd_chk(8'h80, 32'h000000FF);
      check({14'h0000, o_hys_current_na}, 32'h000219E4);
      bus(1'b1, 8'h80, 32'h00000001, 4'h0);
      rd_chk(8'h80, 32'h000000FF);
      wr(8'h80, 32'h00000001);
      cyc(2);
      check({14'h0000, o_hys_current_na}, 32'h0000021C);
      $display("test hysteresis done");
   endtask : t_hysteresis
   task automatic t_compare();
      wr(8'h7C, 32'h00000040);
      wr(8'h80, 32'h00000010);
      rd_chk(8'h7C, 32'h00000040);
      i_dark_cmp_level <= 8'h3F;
      cyc(3);
      check({31'h0, o_dark_mode}, 32'h00000001);
      rd_chk(8'hA4, 32'h00000001);
      i_dark_cmp_level <= 8'h50;
      cyc(3);
      check({31'h0, o_dark_mode}, 32'h00000001);
      i_dark_cmp_level <= 8'h51;
      cyc(3);
      check({31'h0, o_dark_mode}, 32'h00000000);
      i_dark_cmp_level <= 8'h40;
      cyc(3);
      check({31'h0, o_dark_mode}, 32'h00000000);
      i_ce <= 1'b0;
      i_dark_cmp_level <= 8'h3F;
      cyc(3);
      check({31'h0, o_dark_mode}, 32'h00000000);
      i_ce <= 1'b1;
      cyc(3);
      check({31'h0, o_dark_mode}, 32'h00000001);
      $display("test compare done");
   endtask : t_compare
   task automatic t_refresh();
      logic [31:0] exp_a [4];
      exp_a = '{32'h000000BC, 32'h0000001A, 32'h0000005F, 32'h0000000A};
      i_sensor1_value <= 13'h1ABC;
      i_sensor2_value <= 13'h0A5F;
      wr(8'hA0, 32'h00000001);
      cyc(REFRESH + 8);
      for (int i = 0; i < 4; i++) begin
         rd_chk(8'h84 + 8'(i * 4), exp_a[i]);
         wr(8'h84 + 8'(i * 4), 32'hFFFFFFFF);
         rd_chk(8'h84 + 8'(i * 4), exp_a[i]);
      end
      wr(8'hA0, 32'h00000000);
      i_sensor1_value <= 13'h0155;
      i_sensor2_value <= 13'h1F00;
      cyc(REFRESH * 3);
      rd_chk(8'h84, 32'h000000BC);
      wr(8'hA0, 32'h00000001);
      rd_chk(8'h84, 32'h000000BC);
      cyc(REFRESH + 8);
      rd_chk(8'h84, 32'h00000055);
      rd_chk(8'h88, 32'h00000001);
      rd_chk(8'h8C, 32'h00000000);
      rd_chk(8'h90, 32'h0000001F);
      $display("test refresh done");
   endtask : t_refresh

   // ==========================================================
   // main sequence
   initial begin
      i_sys_rst = 1'b1;
      i_ce = 1'b1;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 8'h00;
      i_avs_writedata = 32'h00000000;
      i_avs_byteenable = 4'h0;
      i_dark_cmp_level = 8'h80;
      i_sensor1_value = 13'h0000;
      i_sensor2_value = 13'h0000;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_reset_map();
      t_hysteresis();
      t_compare();
      t_refresh();
      end_of_test();
   end
endmodule : light_sensor_level_readout_bench

bind light_sensor_level_readout light_sensor_level_readout_props #(
   .REFRESH_CYCLES(REFRESH_CYCLES)) chk (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_address(i_avs_address), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable),
   .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
   .i_dark_cmp_level(i_dark_cmp_level), .i_sensor1_value(i_sensor1_value),
   .i_sensor2_value(i_sensor2_value), .o_dark_mode(o_dark_mode),
   .o_hys_current_na(o_hys_current_na));
